// ---- logic/umls_break_det.sv ----
`timescale 1ns/100ps
// break detector: line low for one whole frame gives one pulse
module umls_break_det
   import umls_pkg::*;
(
   input  wire logic sys_clk_i,
   input  wire logic reset_n_i,
   input  wire logic rx_line_i,   // asynchronous pin
   input  wire logic tick_i,
   output logic      break_o
);

   typedef struct packed {
      logic [2:0] sync;    // three-stage synchroniser, [0] is first stage
      logic       level;   // accepted line level
      logic [3:0] lows;    // bit times seen low
      logic       armed;   // cleared after a pulse until line goes high
      logic       pulse;
   } umls_brk_t;

   umls_brk_t q;
   umls_brk_t n;

   always_comb begin
      n = q;
      n.pulse = 1'b0;
      n.sync  = {q.sync[1:0], rx_line_i};
      // a change counts only when stages two and three agree
      if (q.sync[1] == q.sync[2]) begin
         n.level = q.sync[2];
      end
      if (q.level) begin
         n.lows  = 4'h0;
         n.armed = 1'b1;                    // line back high re-arms
      end else if (tick_i && q.armed) begin
         if (q.lows + 4'h1 >= FRAME_BITS) begin
            n.pulse = 1'b1;
            n.armed = 1'b0;                 // one break character per break
            n.lows  = 4'h0;
         end else begin
            n.lows = q.lows + 4'h1;
         end
      end
   end

   always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         q <= '{sync: 3'h7, level: 1'b1, lows: 4'h0, armed: 1'b1, pulse: 1'b0};
      end else begin
         q <= n;
      end
   end

   assign break_o = q.pulse;

endmodule // umls_break_det

// ---- logic/umls_core.sv ----
// Implementation choices: the register addresses and register access over Avalon-MM.
`timescale 1ns/100ps
// Overview of operation
// - control bit one drives active-low output low
// - autoflow makes request-to-send follow receive fill
// - bit five enables automatic flow control
// - fifo error flag set by erroneous character
// - line status read clears fifo error flag once no erroneous entry remains
// - non-fifo: empty only when holding, shifter empty
// - transmitter empty drops when any character held
// - fifo mode: empty when fifo, shifter empty
// - holding empty set when character enters shifter
// - holding empty clears on host character write
// - holding empty with enable raises interrupt
// - fifo mode: holding empty follows fifo empty
// - break after full low frame, one character
module umls_core
   import umls_pkg::*;
(
   input  wire logic        sys_clk_i,
   input  wire logic        reset_n_i,
   // avalon-mm slave
   input  wire logic [4:0]  avs_address_i,
   input  wire logic        avs_read_i,
   input  wire logic        avs_write_i,
   input  wire logic [31:0] avs_writedata_i,
   input  wire logic [3:0]  avs_byteenable_i,
   output logic [31:0]      avs_readdata_o,
   output logic             avs_waitrequest_o,
   // characters from the receiver, same clock; raw receive pin, asynchronous
   input  wire logic        rx_char_valid_i,
   input  wire logic [7:0]  rx_char_i,
   input  wire logic        rx_parity_err_i,
   input  wire logic        rx_frame_err_i,
   input  wire logic        rx_line_i,
   // serial and modem pins
   output logic             tx_o,
   output logic             rts_n_o,
   output logic             dtr_n_o,
   output logic             irq_o
);

   umls_state_t q;                   // all registered state
   umls_state_t n;                   // next value of the state
   logic        tick;                // bit-rate enable
   logic        brk;                 // break detected, one pulse

   // bit clock enable
   umls_tick_gen u_tick (
      .sys_clk_i (sys_clk_i),
      .reset_n_i (reset_n_i),
      .divisor_i (q.divisor),
      .tick_o    (tick)
   );

   // break detection on the raw receive pin
   umls_break_det u_brk (
      .sys_clk_i (sys_clk_i),
      .reset_n_i (reset_n_i),
      .rx_line_i (rx_line_i),
      .tick_i    (tick),
      .break_o   (brk)
   );

   // address match used by both read and write paths
   function automatic logic hit(input logic [4:0] addr, input logic [4:0] off);
      hit = (addr == off);
   endfunction

   // error content of a receive entry
   function automatic logic has_err(input logic [RXE_W-1:0] e);
      has_err = e[RXE_PARITY] | e[RXE_FRAME] | e[RXE_BREAK];
   endfunction

   // combinational views of the state
   logic [4:0]        cap;           // depth in use for the mode
   logic              thre;          // holding register / fifo empty
   logic              temt;          // holding and shifter both empty
   logic [RXE_W-1:0]  rx_top;        // oldest receive entry
   logic [7:0]        lns;           // assembled line_status
   logic              room;          // receive fill below RTS_LEVEL (fifo) or HOLD_DEPTH

   always_comb begin
      cap    = q.fifo_en ? FIFO_DEPTH : HOLD_DEPTH;
      thre   = (q.tx_cnt == 5'h00);
      temt   = thre & ~q.sh_busy;
      rx_top = q.rx_mem[q.rx_rd];
      room   = (q.rx_cnt < (q.fifo_en ? RTS_LEVEL : HOLD_DEPTH));
      lns    = 8'h00;
      lns[LNS_DR]      = (q.rx_cnt != 5'h00);
      lns[LNS_OVERRUN] = q.overrun;
      lns[LNS_PARITY]  = lns[LNS_DR] & rx_top[RXE_PARITY];
      lns[LNS_FRAME]   = lns[LNS_DR] & rx_top[RXE_FRAME];
      lns[LNS_BREAK]   = lns[LNS_DR] & rx_top[RXE_BREAK];
      lns[LNS_THRE]    = thre;
      lns[LNS_TEMT]    = temt;
      lns[LNS_FIFOERR] = q.fifo_err;
   end

   // bus handshake, queue movement and flags
   logic              acc;           // first cycle of a request
   logic              done_rd;       // read side effects land at this edge
   logic              done_wr;       // write completes at this edge
   logic              tx_push;
   logic              tx_pop;
   logic              rx_push;
   logic              rx_pop;
   logic [RXE_W-1:0]  rx_word;
   logic [4:0]        err_next;
   logic              mode_chg;
   logic [IRQ_W-1:0]  ev;            // interrupt events this cycle

   always_comb begin
      n = q;
      acc     = (avs_read_i | avs_write_i) & ~q.ack;
      // read side effects land with the data capture, so an event that
      // arrives between capture and completion is never cleared unseen
      done_rd = acc & avs_read_i;
      done_wr = avs_write_i & q.ack;
      n.ack   = acc;                  // answer one cycle after the request
      ev      = '0;

      // read data captured in the request cycle; unmapped reads give zero
      if (acc && avs_read_i) begin
         n.rdata = 32'h0000_0000;
         case (avs_address_i)
            OFF_DATA:      n.rdata[7:0]       = lns[LNS_DR] ? rx_top[7:0] : 8'h00;
            OFF_FIFO_CTRL: n.rdata[0]         = q.fifo_en;
            OFF_MOC:       n.rdata[7:0]       = q.moc;
            OFF_LNS:       n.rdata[7:0]       = lns;
            OFF_IRQ_STAT:  n.rdata[IRQ_W-1:0] = q.irq_stat;
            OFF_IRQ_MASK:  n.rdata[IRQ_W-1:0] = q.irq_mask;
            OFF_DIVISOR:   n.rdata[15:0]      = q.divisor;
            default:       n.rdata            = 32'h0000_0000;
         endcase
      end

      // control registers, lane by lane
      mode_chg = 1'b0;
      if (done_wr && avs_byteenable_i[0]) begin
         if (hit(avs_address_i, OFF_MOC)) begin
            n.moc = avs_writedata_i[7:0] & MOC_WMASK;
         end
         if (hit(avs_address_i, OFF_IRQ_MASK)) begin
            n.irq_mask = avs_writedata_i[IRQ_W-1:0];
         end
         if (hit(avs_address_i, OFF_FIFO_CTRL)) begin
            n.fifo_en = avs_writedata_i[0];
            mode_chg  = (avs_writedata_i[0] != q.fifo_en);
         end
         if (hit(avs_address_i, OFF_DIVISOR)) begin
            n.divisor[7:0] = avs_writedata_i[7:0];
         end
      end
      if (done_wr && avs_byteenable_i[1] && hit(avs_address_i, OFF_DIVISOR)) begin
         n.divisor[15:8] = avs_writedata_i[15:8];
      end

      // transmit side: host writes fill, shifter drains
      // a write to a full queue is dropped; software must poll holding-empty
      tx_push = done_wr && avs_byteenable_i[0] && hit(avs_address_i, OFF_DATA)
                && (q.tx_cnt < cap);
      tx_pop  = ~q.sh_busy && (q.tx_cnt != 5'h00);
      if (tx_push) begin
         n.tx_mem[q.tx_wr] = avs_writedata_i[7:0];
         n.tx_wr           = q.tx_wr + 4'h1;
      end
      if (tx_pop) begin
         n.sh      = {1'b1, q.tx_mem[q.tx_rd], 1'b0};    // stop, data, start
         n.sh_bits = 4'h0;
         n.sh_busy = 1'b1;
         n.tx_rd   = q.tx_rd + 4'h1;
      end else if (q.sh_busy && tick) begin
         if (q.sh_bits == FRAME_BITS) begin
            n.sh_busy = 1'b0;                           // stop bit held a full bit time
         end else begin
            n.tx_line = q.sh[0];
            n.sh      = {1'b1, q.sh[9:1]};
            n.sh_bits = q.sh_bits + 4'h1;
         end
      end
      // write clears holding-empty at the same edge it is stored
      n.tx_cnt = q.tx_cnt + {4'h0, tx_push} - {4'h0, tx_pop};

      // receive side: break beats a same-cycle character, which counts as overrun
      rx_word = brk ? RXE_W'(1) << RXE_BREAK
                    : {1'b0, rx_frame_err_i, rx_parity_err_i, rx_char_i};
      rx_pop  = done_rd && hit(avs_address_i, OFF_DATA) && (q.rx_cnt != 5'h00);
      rx_push = (brk | rx_char_valid_i) && (q.rx_cnt < cap);
      if ((rx_char_valid_i && brk) || ((brk | rx_char_valid_i) && !rx_push)) begin
         n.overrun = 1'b1;
      end else if (done_rd && hit(avs_address_i, OFF_LNS)) begin
         n.overrun = 1'b0;
      end
      if (rx_push) begin
         n.rx_mem[q.rx_wr] = rx_word;
         n.rx_wr           = q.rx_wr + 4'h1;
      end
      if (rx_pop) begin
         n.rx_rd = q.rx_rd + 4'h1;
      end
      n.rx_cnt = q.rx_cnt + {4'h0, rx_push} - {4'h0, rx_pop};
      err_next = q.rx_err_cnt + {4'h0, rx_push & has_err(rx_word)}
                 - {4'h0, rx_pop & has_err(rx_top)};
      n.rx_err_cnt = err_next;

      // fifo error flag: a new error wins over the clearing read
      if (rx_push && has_err(rx_word)) begin
         n.fifo_err = 1'b1;
         ev[IRQ_ERR] = 1'b1;
      end else if (done_rd && hit(avs_address_i, OFF_LNS)) begin
         n.fifo_err = (err_next != 5'h00);
      end
      ev[IRQ_BREAK] = brk;

      // switching mode flushes both queues
      if (mode_chg) begin
         n.tx_wr      = 4'h0;
         n.tx_rd      = 4'h0;
         n.tx_cnt     = 5'h00;
         n.rx_wr      = 4'h0;
         n.rx_rd      = 4'h0;
         n.rx_cnt     = 5'h00;
         n.rx_err_cnt = 5'h00;
      end

      // sticky interrupt status, read clears, same-cycle event wins
      n.thre_q = thre;
      ev[IRQ_THRE] = thre & ~q.thre_q;
      if (done_rd && hit(avs_address_i, OFF_IRQ_STAT)) begin
         n.irq_stat = ev;
      end else begin
         n.irq_stat = q.irq_stat | ev;
      end
   end

   // single state register
   always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         q         <= '0;
         q.tx_line <= 1'b1;
         q.thre_q  <= 1'b1;
         q.moc     <= MOC_RESET;
         q.divisor <= DIVISOR_RESET;
      end else begin
         q <= n;
      end
   end

   // outputs
   assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~q.ack;
   assign avs_readdata_o    = q.rdata;
   assign tx_o              = q.tx_line;
   assign dtr_n_o           = ~q.moc[MOC_DTR];
   // auto flow: request drops while the receive side is near full
   assign rts_n_o = ~(q.moc[MOC_RTS] & (~q.moc[MOC_AUTOFLOW] | room));
   // holding-empty is a level source gated by its enable
   assign irq_o = (thre & q.irq_mask[IRQ_THRE])
                | (|(q.irq_stat[IRQ_BREAK:IRQ_ERR] & q.irq_mask[IRQ_BREAK:IRQ_ERR]));

endmodule // umls_core

// ---- logic/umls_pkg.sv ----
// shared constants and state types for the modem output / line status block
package umls_pkg;

   // register byte offsets on the avalon slave
   localparam logic [4:0] OFF_DATA      = 5'h00;  // write: tx char, read: rx char
   localparam logic [4:0] OFF_FIFO_CTRL = 5'h04;  // bit 0 selects fifo operation
   localparam logic [4:0] OFF_MOC       = 5'h08;  // modem_output_control
   localparam logic [4:0] OFF_LNS       = 5'h0c;  // line_status, read only
   localparam logic [4:0] OFF_IRQ_STAT  = 5'h10;  // sticky events, cleared by read
   localparam logic [4:0] OFF_IRQ_MASK  = 5'h14;  // same layout as status
   localparam logic [4:0] OFF_DIVISOR   = 5'h18;  // bit clock divisor, 16 bits

   // modem_output_control fields
   localparam int unsigned MOC_DTR      = 0;      // data terminal ready request
   localparam int unsigned MOC_RTS      = 1;      // request to send
   localparam int unsigned MOC_AUTOFLOW = 5;      // automatic flow control enable
   localparam logic [7:0]  MOC_WMASK    = 8'h3f;  // bits 7:6 stay zero
   localparam logic [7:0]  MOC_RESET    = 8'h00;

   // line_status fields
   localparam int unsigned LNS_DR      = 0;
   localparam int unsigned LNS_OVERRUN = 1;
   localparam int unsigned LNS_PARITY  = 2;
   localparam int unsigned LNS_FRAME   = 3;
   localparam int unsigned LNS_BREAK   = 4;
   localparam int unsigned LNS_THRE    = 5;
   localparam int unsigned LNS_TEMT    = 6;
   localparam int unsigned LNS_FIFOERR = 7;

   // interrupt status / mask fields
   localparam int unsigned IRQ_THRE  = 0;         // mask bit is the tx interrupt enable
   localparam int unsigned IRQ_ERR   = 1;
   localparam int unsigned IRQ_BREAK = 2;
   localparam int unsigned IRQ_W     = 3;

   // rx fifo entry layout
   localparam int unsigned RXE_PARITY = 8;
   localparam int unsigned RXE_FRAME  = 9;
   localparam int unsigned RXE_BREAK  = 10;
   localparam int unsigned RXE_W      = 11;

   // sizes and counts
   localparam logic [4:0]  FIFO_DEPTH    = 5'h10;  // 16 characters each way
   localparam logic [4:0]  HOLD_DEPTH    = 5'h01;  // non-fifo: one holding register
   localparam logic [4:0]  RTS_LEVEL     = 5'h0e;  // auto flow drops request at this fill
   localparam logic [3:0]  FRAME_BITS    = 4'ha;   // start, 8 data, stop
   localparam logic [15:0] DIVISOR_RESET = 16'h0001;

   typedef struct packed {
      logic [15:0][7:0]        tx_mem;     // transmit holding register / fifo
      logic [3:0]              tx_wr;
      logic [3:0]              tx_rd;
      logic [4:0]              tx_cnt;
      logic [15:0][RXE_W-1:0]  rx_mem;     // receive holding register / fifo
      logic [3:0]              rx_wr;
      logic [3:0]              rx_rd;
      logic [4:0]              rx_cnt;
      logic [4:0]              rx_err_cnt; // entries carrying an error
      logic [9:0]              sh;         // transmit shift register
      logic [3:0]              sh_bits;
      logic                    sh_busy;
      logic                    tx_line;
      logic                    fifo_en;
      logic [7:0]              moc;
      logic [15:0]             divisor;
      logic                    fifo_err;
      logic                    overrun;
      logic [IRQ_W-1:0]        irq_stat;
      logic [IRQ_W-1:0]        irq_mask;
      logic                    thre_q;     // previous holding-empty level
      logic                    ack;
      logic [31:0]             rdata;
   } umls_state_t;

endpackage

// ---- logic/umls_tick_gen.sv ----
`timescale 1ns/100ps
// one-cycle bit-rate enable from the system clock
module umls_tick_gen
   import umls_pkg::*;
(
   input  wire logic        sys_clk_i,
   input  wire logic        reset_n_i,
   input  wire logic [15:0] divisor_i,
   output logic             tick_o
);

   typedef struct packed {
      logic [15:0] cnt;   // cycles since last tick
      logic        tick;
   } umls_tick_t;

   umls_tick_t q;
   umls_tick_t n;

   // divisor 0 behaves as 1, so the enable never stops
   always_comb begin
      n = q;
      n.tick = 1'b0;
      if (q.cnt + 16'h0001 >= divisor_i) begin
         n.cnt  = 16'h0000;
         n.tick = 1'b1;
      end else begin
         n.cnt = q.cnt + 16'h0001;
      end
   end

   always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         q <= '0;
      end else begin
         q <= n;
      end
   end

   assign tick_o = q.tick;

endmodule // umls_tick_gen

// ---- test/tb.sv ----
`timescale 1ns/100ps
// bench: bus tasks against a queue model of line status
module tb
   import umls_pkg::*;
   ;
   logic        sys_clk_i = 1'b0;          // 20 mhz
   logic        reset_n_i = 1'b0;
   logic [4:0]  avs_address_i = 5'h00;
   logic        avs_read_i = 1'b0;
   logic        avs_write_i = 1'b0;
   logic [31:0] avs_writedata_i = 32'h0;
   logic [3:0]  avs_byteenable_i = 4'hf;   // tied: full words only
   logic [31:0] avs_readdata_o;
   logic        avs_waitrequest_o;
   logic        rx_char_valid_i;
   logic [7:0]  rx_char_i;
   logic        rx_parity_err_i;
   logic        rx_frame_err_i;
   logic        rx_line_i;
   logic        tx_o;
   logic        rts_n_o;
   logic        dtr_n_o;
   logic        irq_o;
   int          errors = 0;
   int          comparisons = 0;
   int          rxq[$];                    // model queue: data, parity, frame, break
   logic        fe = 1'b0;                 // model fifo error flag
   logic [31:0] q;                         // last read data
   logic [31:0] v;
   umls_core umls_core_i (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i),
      .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
      .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
      .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
      .rx_char_valid_i(rx_char_valid_i), .rx_char_i(rx_char_i),
      .rx_parity_err_i(rx_parity_err_i), .rx_frame_err_i(rx_frame_err_i),
      .rx_line_i(rx_line_i), .tx_o(tx_o), .rts_n_o(rts_n_o), .dtr_n_o(dtr_n_o),
      .irq_o(irq_o));
   umls_rx_src umls_rx_src_i (.sys_clk_i(sys_clk_i), .rx_char_valid_o(rx_char_valid_i),
      .rx_char_o(rx_char_i), .rx_parity_err_o(rx_parity_err_i),
      .rx_frame_err_o(rx_frame_err_i), .rx_line_o(rx_line_i));
   // free-running clock
   always #25 sys_clk_i = ~sys_clk_i;
   task automatic cmp(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         errors++;
         $display("mismatch %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic end_of_test();
      $display("errors %0d comparisons %0d", errors, comparisons);
      if (errors == 0 && comparisons > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   // one transfer: held until waitrequest is seen low at a rising edge,
   // data taken at that edge, released after it; one idle edge follows
   task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
      int n;
      n = 0;
      avs_address_i   <= a;
      avs_writedata_i <= d;
      avs_write_i     <= wr;
      avs_read_i      <= !wr;
      @(posedge sys_clk_i);
      while (avs_waitrequest_o !== 1'b0) begin
         n++;
         if (n > 20) begin
            errors++;
            end_of_test();
         end
         @(posedge sys_clk_i);
      end
      q = avs_readdata_o;
      avs_write_i <= 1'b0;
      avs_read_i  <= 1'b0;
      @(posedge sys_clk_i);
   endtask
   task automatic rd(input logic [4:0] a, input logic [31:0] e, input string nm);
      bus(1'b0, a, 32'h0);
      cmp(nm, q, e);
   endtask
   // expected line_status; flag clears when no erroneous entry remains
   task automatic lns_chk(input logic thre, input logic temt);
      logic [2:0] t;
      int n;
      t = (rxq.size() > 0) ? 3'(rxq[0] >> 8) : 3'h0;
      rd(OFF_LNS, {24'h0, fe, temt, thre, t, 1'b0, rxq.size() > 0}, "line_status");
      n = 0;
      foreach (rxq[i]) if (rxq[i] > 255) n++;
      if (n == 0) fe = 1'b0;
   endtask
   task automatic push(input logic [7:0] d, input logic p, input logic f);
      umls_rx_src_i.send(d, p, f);
      rxq.push_back(int'(d) | (int'(p) << 8) | (int'(f) << 9));
      if (p | f) fe = 1'b1;
   endtask
   task automatic pop();
      rd(OFF_DATA, rxq[0] & 8'hff, "rx_char");
      void'(rxq.pop_front());
   endtask
   task automatic wait_irq();
      int n;
      n = 0;
      while (irq_o !== 1'b1 && n < 300) begin
         @(posedge sys_clk_i);
         n++;
      end
      cmp("irq", irq_o, 1'b1);
   endtask
   // cut a hang short
   initial begin
      repeat (20000) @(posedge sys_clk_i);
      errors++;
      end_of_test();
   end
   initial begin
      void'($urandom(44));
      repeat (20) @(posedge sys_clk_i);
      reset_n_i <= 1'b1;
      @(posedge sys_clk_i);
      // reset state and an unmapped place
      rd(OFF_MOC, 32'h0, "modem_output_control");
      cmp("dtr_n", dtr_n_o, 1'b1);
      lns_chk(1'b1, 1'b1);
      rd(5'h1c, 32'h0, "unmapped");
      // random control values; receive queue empty so rts follows its bit
      for (int i = 0; i < 8; i++) begin
         v = $urandom & 32'hff;
         bus(1'b1, OFF_MOC, v);
         rd(OFF_MOC, v & MOC_WMASK, "modem_output_control");
         cmp("dtr_n", dtr_n_o, !v[MOC_DTR]);
         cmp("rts_n", rts_n_o, !v[MOC_RTS]);
      end
      // non-fifo transmit: slow bit clock keeps the shifter busy
      bus(1'b1, OFF_DIVISOR, 32'h4);
      bus(1'b1, OFF_IRQ_MASK, 32'h1);
      cmp("irq", irq_o, 1'b1);
      bus(1'b1, OFF_DATA, 32'h5a);
      bus(1'b1, OFF_DATA, 32'ha5);
      lns_chk(1'b0, 1'b0);
      cmp("irq", irq_o, 1'b0);
      wait_irq();
      lns_chk(1'b1, 1'b0);
      repeat (100) @(posedge sys_clk_i);
      lns_chk(1'b1, 1'b1);
      cmp("tx", tx_o, 1'b1);
      // fifo transmit
      bus(1'b1, OFF_FIFO_CTRL, 32'h1);
      for (int i = 0; i < 3; i++) bus(1'b1, OFF_DATA, $urandom & 32'hff);
      lns_chk(1'b0, 1'b0);
      wait_irq();
      lns_chk(1'b1, 1'b0);
      repeat (100) @(posedge sys_clk_i);
      lns_chk(1'b1, 1'b1);
      cmp("tx", tx_o, 1'b1);
      // automatic request-to-send against receive fill
      bus(1'b1, OFF_IRQ_MASK, 32'h0);
      bus(1'b1, OFF_MOC, 32'h22);
      for (int i = 0; i < 14; i++) begin
         cmp("rts_n", rts_n_o, 1'b0);
         push($urandom & 32'hff, 1'b0, 1'b0);
      end
      cmp("rts_n", rts_n_o, 1'b1);
      bus(1'b1, OFF_MOC, 32'h02);
      cmp("rts_n", rts_n_o, 1'b0);
      bus(1'b1, OFF_FIFO_CTRL, 32'h0);
      bus(1'b1, OFF_FIFO_CTRL, 32'h1);
      rxq.delete();
      // receive errors, sticky flag and error interrupt
      bus(1'b0, OFF_IRQ_STAT, 32'h0);
      bus(1'b1, OFF_IRQ_MASK, 32'h2);
      push(8'h31, 1'b1, 1'b0);
      push(8'h32, 1'b0, 1'b1);
      push(8'h33, 1'b0, 1'b0);
      cmp("irq", irq_o, 1'b1);
      rd(OFF_IRQ_STAT, 32'h2, "irq_status");
      cmp("irq", irq_o, 1'b0);
      for (int i = 0; i < 3; i++) begin
         lns_chk(1'b1, 1'b1);
         pop();
      end
      lns_chk(1'b1, 1'b1);
      // long low line gives exactly one break entry
      umls_rx_src_i.hold_low(80);
      rxq.push_back(32'h400);
      fe = 1'b1;
      lns_chk(1'b1, 1'b1);
      pop();
      lns_chk(1'b1, 1'b1);
      lns_chk(1'b1, 1'b1);
      end_of_test();
   end
endmodule // tb

// ---- test/umls_core_assertions.sv ----
`timescale 1ns/100ps
// port-level checker; shadows track completed register writes
module umls_core_assertions
   import umls_pkg::*;
(
   input wire logic        sys_clk_i,
   input wire logic        reset_n_i,
   input wire logic [4:0]  avs_address_i,
   input wire logic        avs_read_i,
   input wire logic        avs_write_i,
   input wire logic [31:0] avs_writedata_i,
   input wire logic [3:0]  avs_byteenable_i,
   input wire logic [31:0] avs_readdata_o,
   input wire logic        avs_waitrequest_o,
   input wire logic        tx_o,
   input wire logic        rts_n_o,
   input wire logic        dtr_n_o,
   input wire logic        irq_o
);
   logic [7:0]       moc_q;   // shadow of modem_output_control
   logic [IRQ_W-1:0] mask_q;  // shadow of interrupt mask
   logic             wdone;   // write lands at this edge
   logic             lns_rd;  // line_status data on the bus
   assign wdone  = avs_write_i & ~avs_waitrequest_o & avs_byteenable_i[0];
   assign lns_rd = avs_read_i & ~avs_waitrequest_o & (avs_address_i == OFF_LNS);
   // shadows update on the same edge as the device registers
   always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         moc_q  <= MOC_RESET;
         mask_q <= '0;
      end else if (wdone) begin
         if (avs_address_i == OFF_MOC) moc_q <= avs_writedata_i[7:0] & MOC_WMASK;
         if (avs_address_i == OFF_IRQ_MASK) mask_q <= avs_writedata_i[IRQ_W-1:0];
      end
   end
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (!reset_n_i);
   chk_dtr_level: assert property (dtr_n_o == !moc_q[MOC_DTR])
      else $error("dtr output disagrees with control bit");
   chk_rts_manual: assert property (
      !moc_q[MOC_AUTOFLOW] |-> rts_n_o == !moc_q[MOC_RTS])
      else $error("rts output disagrees with control bit");
   chk_rts_auto: assert property (!moc_q[MOC_RTS] |-> rts_n_o)
      else $error("rts asserted without control bit");
   chk_thre_write: assert property (
      wdone && avs_address_i == OFF_DATA && mask_q == 3'h1 |=> !irq_o)
      else $error("holding empty still set after character write");
   chk_irq_masked: assert property (mask_q == '0 |-> !irq_o)
      else $error("interrupt raised while fully masked");
   chk_irq_thre: assert property (
      lns_rd && mask_q == 3'h1 |-> $past(irq_o) == avs_readdata_o[LNS_THRE])
      else $error("interrupt disagrees with holding empty flag");
   chk_temt_idle: assert property (lns_rd && avs_readdata_o[LNS_TEMT] |-> tx_o)
      else $error("transmitter empty while line not idle");
   chk_temt_thre: assert property (
      lns_rd && avs_readdata_o[LNS_TEMT] |-> avs_readdata_o[LNS_THRE])
      else $error("transmitter empty with holding register full");
   chk_err_flag: assert property (
      lns_rd && |avs_readdata_o[LNS_BREAK:LNS_PARITY] |-> avs_readdata_o[LNS_FIFOERR])
      else $error("erroneous top entry without fifo error flag");
endmodule // umls_core_assertions

bind umls_core umls_core_assertions umls_core_assertions_i (
   .sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .avs_address_i(avs_address_i),
   .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
   .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
   .avs_waitrequest_o(avs_waitrequest_o), .tx_o(tx_o), .rts_n_o(rts_n_o),
   .dtr_n_o(dtr_n_o), .irq_o(irq_o));

// ---- test/umls_rx_src.sv ----
`timescale 1ns/100ps
// receiver side: characters with error flags, and the raw line
module umls_rx_src (
   input  wire logic  sys_clk_i,
   output logic       rx_char_valid_o,
   output logic [7:0] rx_char_o,
   output logic       rx_parity_err_o,
   output logic       rx_frame_err_o,
   output logic       rx_line_o
);
   // idle: no strobe, line high as if pulled up
   initial begin
      rx_char_valid_o = 1'b0;
      rx_char_o       = 8'h00;
      rx_parity_err_o = 1'b0;
      rx_frame_err_o  = 1'b0;
      rx_line_o       = 1'b1;
   end
   // one-cycle strobe; lines then flip so stale data never passes
   task automatic send(input logic [7:0] d, input logic p, input logic f);
      rx_char_valid_o <= 1'b1;
      rx_char_o       <= d;
      rx_parity_err_o <= p;
      rx_frame_err_o  <= f;
      @(posedge sys_clk_i);
      rx_char_valid_o <= 1'b0;
      rx_char_o       <= ~d;
      rx_parity_err_o <= ~p;
      rx_frame_err_o  <= ~f;
      @(posedge sys_clk_i);
   endtask
   // line held low n cycles, then idle as long
   task automatic hold_low(input int n);
      rx_line_o <= 1'b0;
      repeat (n) @(posedge sys_clk_i);
      rx_line_o <= 1'b1;
      repeat (n) @(posedge sys_clk_i);
   endtask
endmodule // umls_rx_src
